// [hw/rq_stream_pkg.sv]
// Overview of operation
// - second start lane: 10 means lane 32
// - end flags: 00 none, 01 one, 11 two
// - no straddle: only low end bit counts
// - first end offset valid with low bit
// - second end offset valid with high bit
// - no straddle: core ends packet on tlast
// - core nullifies a TLP with abort set
// - abort never in a TLP's first beat
// - after abort: end now or finish payload
// - abort stays sticky until packet end
// - abort sampled only with ready high
// - no new TLP beside an aborted end; user still pairs one there after a mid-packet abort without cut
// - endpoint reports aborted TLP as error
`default_nettype none

package rq_stream_pkg;

   localparam int unsigned DATA_W     = 512;
   localparam int unsigned USER_W     = 37;
   localparam int unsigned DWORDS     = 16;
   localparam int unsigned SOP1_LSB   = 24;
   localparam int unsigned EOP_LSB    = 26;
   localparam int unsigned EOP0_LSB   = 28;
   localparam int unsigned EOP1_LSB   = 32;
   localparam int unsigned ABORT_BIT  = 36;

   localparam logic [1:0] SOP1_LANE32 = 2'h2;
   localparam logic [1:0] EOP_NONE    = 2'h0;
   localparam logic [1:0] EOP_ONE     = 2'h1;
   localparam logic [1:0] EOP_TWO     = 2'h3;

   // controller register map, word addresses
   localparam logic [3:0] REG_CTRL       = 4'h0;
   localparam logic [3:0] REG_LENGTH     = 4'h1;
   localparam logic [3:0] REG_ABORT_BEAT = 4'h2;
   localparam logic [3:0] REG_OFFSETS    = 4'h3;
   localparam logic [3:0] REG_IRQ_STATUS = 4'h4;
   localparam logic [3:0] REG_IRQ_CLEAR  = 4'h5;
   localparam logic [3:0] REG_IRQ_ENABLE = 4'h6;
   localparam logic [3:0] REG_BEATS_SENT = 4'h7;

   localparam int unsigned CTRL_START    = 0;
   localparam int unsigned CTRL_STRADDLE = 1;
   localparam int unsigned CTRL_CUT      = 2;
   localparam int unsigned CTRL_PAIR     = 3;
   localparam int unsigned CTRL_BUSY     = 4;

   localparam int unsigned IRQ_DONE      = 0;
   localparam int unsigned IRQ_ABORTED   = 1;
   localparam int unsigned IRQ_W         = 2;

   localparam logic [7:0]  LENGTH_RESET  = 8'h01;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SEND,
      ST_TAIL
   } send_state_e;

endpackage

`default_nettype wire

// [hw/rq_stream_if.sv]
`default_nettype none

interface rq_stream_if;
   import rq_stream_pkg::*;

   logic                tvalid;
   logic                tready;
   logic                tlast;
   logic [DATA_W-1:0]   tdata;
   logic [USER_W-1:0]   tuser;

   modport core
   (
      input  tvalid,
      input  tlast,
      input  tdata,
      input  tuser,
      output tready
   );

   modport user
   (
      output tvalid,
      output tlast,
      output tdata,
      output tuser,
      input  tready
   );

endinterface

`default_nettype wire

// [hw/rq_stream_core.sv]
`default_nettype none

module rq_stream_core
   import rq_stream_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset_n,
   rq_stream_if.core        bus,
   input  wire logic        i_link_ready,
   input  wire logic        i_straddle_en,
   input  wire logic        i_endpoint_mode,
   output logic             o_tlp_sent,
   output logic             o_tlp_nullified,
   output logic             o_aer_report,
   output logic [3:0]       o_last_offset,
   output logic [15:0]      o_tlp_count
);

   logic       beat;
   logic [1:0] end_flags;
   logic       end_first;
   logic       end_second;
   logic       first_bad;
   logic       abort_sticky;
   logic [1:0] good_ends;

   ////////////////////////////////////////////////////////////////////////////
   // beat qualified by handshake
   assign beat = bus.tvalid && bus.tready;
   assign end_flags = bus.tuser[EOP_LSB +: 2];

   always_comb
   begin
      if (i_straddle_en)
      begin
         end_first  = (end_flags == EOP_ONE) || (end_flags == EOP_TWO);
         end_second = (end_flags == EOP_TWO);
      end
      else
      begin
         end_first  = bus.tlast;
         end_second = 1'b0;
      end
      first_bad    = abort_sticky || bus.tuser[ABORT_BIT];
      good_ends    = {1'b0, end_first && !first_bad} + {1'b0, end_second};
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         bus.tready <= 1'b0;
      else
         bus.tready <= i_link_ready;
   end

   // a packet opened at lane 32 starts clean
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         abort_sticky <= 1'b0;
      else if (beat)
      begin
         if (end_first)
            abort_sticky <= 1'b0;
         else
            abort_sticky <= first_bad;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_tlp_sent      <= 1'b0;
         o_tlp_nullified <= 1'b0;
         o_aer_report    <= 1'b0;
      end
      else
      begin
         o_tlp_sent      <= beat && (good_ends != 2'h0);
         o_tlp_nullified <= beat && end_first && first_bad;
         o_aer_report    <= beat && end_first && first_bad && i_endpoint_mode;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         o_last_offset <= 4'h0;
      else if (beat && end_second)
         o_last_offset <= bus.tuser[EOP1_LSB +: 4];
      else if (beat && end_first)
         o_last_offset <= bus.tuser[EOP0_LSB +: 4];
   end

   // nullified packets are not counted
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         o_tlp_count <= 16'h0000;
      else if (beat)
         o_tlp_count <= o_tlp_count + {14'h0000, good_ends};
   end

endmodule

`default_nettype wire

// [hw/rq_stream_user.sv]
// The implementer's own choices: the register addresses and the plain strobed port.
`default_nettype none

module rq_stream_user
   import rq_stream_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset_n,
   rq_stream_if.user        bus,
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   output logic             o_irq
);

   send_state_e       state;
   logic              straddle_en;
   logic              cut_on_abort;
   logic              pair_mode;
   logic [7:0]        length;
   logic [7:0]        abort_beat;
   logic [3:0]        first_off;
   logic [3:0]        second_off;
   logic [IRQ_W-1:0]  irq_status;
   logic [IRQ_W-1:0]  irq_enable;
   logic [15:0]       beats_sent;
   logic [7:0]        beat_idx;
   logic              tail_pending;
   logic              accepted;
   logic              start_cmd;
   logic              clear_wr;
   logic [IRQ_W-1:0]  ev;
   logic [7:0]        next_idx;
   logic              next_last;
   logic              next_abort;
   logic              cur_is_last;
   logic              use_straddle;
   logic              use_cut;
   logic              use_pair;
   logic [IRQ_W-1:0]  next_status;

   ////////////////////////////////////////////////////////////////////////////
   // sideband word for one beat
   function automatic logic [USER_W-1:0] pack_user
   (
      input logic       abort,
      input logic [1:0] eop,
      input logic [1:0] sop1,
      input logic [3:0] off0,
      input logic [3:0] off1
   );
      logic [USER_W-1:0] u;
      u = '0;
      u[ABORT_BIT]       = abort;
      u[EOP_LSB +: 2]    = eop;
      u[SOP1_LSB +: 2]   = sop1;
      u[EOP0_LSB +: 4]   = off0;
      u[EOP1_LSB +: 4]   = off1;
      return u;
   endfunction

   // abort beat index zero means none
   function automatic logic abort_at(input logic [7:0] idx, input logic [7:0] ab, input logic [7:0] len);
      return (ab != 8'h00) && (idx == ab) && (ab < len);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   assign accepted    = bus.tvalid && bus.tready;
   assign start_cmd   = i_wr && (i_addr == REG_CTRL) && i_wdata[CTRL_START] && (state == ST_IDLE);
   assign clear_wr    = i_wr && (i_addr == REG_IRQ_CLEAR);
   assign cur_is_last = (state == ST_TAIL) || bus.tlast;

   always_comb
   begin
      // a start write carries the modes for its own first beat
      use_straddle = start_cmd ? i_wdata[CTRL_STRADDLE] : straddle_en;
      use_cut      = start_cmd ? i_wdata[CTRL_CUT] : cut_on_abort;
      use_pair     = start_cmd ? i_wdata[CTRL_PAIR] : pair_mode;
      next_idx   = (state == ST_IDLE) ? 8'h00 : beat_idx + 8'h01;
      next_abort = abort_at(next_idx, abort_beat, length);
      // end early or run to full length
      next_last  = (next_idx == length - 8'h01) || (use_cut && next_abort);
      ev         = '0;
      ev[IRQ_DONE]    = accepted && cur_is_last && !tail_pending;
      ev[IRQ_ABORTED] = accepted && bus.tuser[ABORT_BIT];
      next_status     = (irq_status & ~(clear_wr ? i_wdata[IRQ_W-1:0] : '0)) | ev;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         straddle_en  <= 1'b0;
         cut_on_abort <= 1'b0;
         pair_mode    <= 1'b0;
         length       <= LENGTH_RESET;
         abort_beat   <= 8'h00;
         first_off    <= 4'h0;
         second_off   <= 4'h0;
         irq_enable   <= '0;
      end
      else if (i_wr && (state == ST_IDLE))
      begin
         unique case (i_addr)
            REG_CTRL:
            begin
               straddle_en  <= i_wdata[CTRL_STRADDLE];
               cut_on_abort <= i_wdata[CTRL_CUT];
               pair_mode    <= i_wdata[CTRL_PAIR];
            end
            REG_LENGTH:
               length <= (i_wdata[7:0] == 8'h00) ? LENGTH_RESET : i_wdata[7:0];
            REG_ABORT_BEAT:
               abort_beat <= i_wdata[7:0];
            REG_OFFSETS:
            begin
               first_off  <= i_wdata[3:0];
               second_off <= i_wdata[7:4];
            end
            REG_IRQ_ENABLE:
               irq_enable <= i_wdata[IRQ_W-1:0];
            default:
            begin
            end
         endcase
      end
      else if (i_wr && (i_addr == REG_IRQ_ENABLE))
         irq_enable <= i_wdata[IRQ_W-1:0];
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         irq_status <= '0;
      else
         irq_status <= next_status;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         o_irq <= 1'b0;
      else
         o_irq <= |(next_status & irq_enable);
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         beats_sent <= 16'h0000;
      else if (accepted)
         beats_sent <= beats_sent + 16'h0001;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         o_rdata <= 32'h0000_0000;
      else if (i_rd)
      begin
         unique case (i_addr)
            REG_CTRL:
               o_rdata <= {27'h0, state != ST_IDLE, pair_mode, cut_on_abort, straddle_en, 1'b0};
            REG_LENGTH:
               o_rdata <= {24'h0, length};
            REG_ABORT_BEAT:
               o_rdata <= {24'h0, abort_beat};
            REG_OFFSETS:
               o_rdata <= {24'h0, second_off, first_off};
            REG_IRQ_STATUS:
               o_rdata <= {30'h0, irq_status};
            REG_IRQ_ENABLE:
               o_rdata <= {30'h0, irq_enable};
            REG_BEATS_SENT:
               o_rdata <= {16'h0, beats_sent};
            default:
               o_rdata <= 32'h0000_0000;
         endcase
      end
      else
         o_rdata <= 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // beats change only after acceptance, so an abort is held through ready low
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         state        <= ST_IDLE;
         beat_idx     <= 8'h00;
         tail_pending <= 1'b0;
         bus.tvalid   <= 1'b0;
         bus.tlast    <= 1'b0;
         bus.tdata    <= '0;
         bus.tuser    <= '0;
      end
      else if (start_cmd || (accepted && !cur_is_last))
      begin
         state      <= ST_SEND;
         beat_idx   <= next_idx;
         bus.tvalid <= 1'b1;
         bus.tlast  <= next_last;
         bus.tdata  <= {DWORDS{24'h000000, next_idx}};
         if (!next_last)
            bus.tuser <= pack_user(next_abort, EOP_NONE, 2'h0, 4'h0, 4'h0);
         else if (!use_straddle)
            bus.tuser <= pack_user(next_abort, EOP_ONE, 2'h0, first_off, 4'h0);
         else if (use_pair && !next_abort)
            bus.tuser <= pack_user(1'b0, EOP_TWO, SOP1_LANE32, first_off, second_off);
         else
            bus.tuser <= pack_user(next_abort, EOP_ONE, 2'h0, first_off, 4'h0);
         // short TLP moves past an end beat that carries the abort itself
         tail_pending <= next_last && use_straddle && use_pair && next_abort;
      end
      else if (accepted && tail_pending)
      begin
         state        <= ST_TAIL;
         tail_pending <= 1'b0;
         bus.tlast    <= 1'b1;
         bus.tdata    <= {DWORDS{32'hffff_ffff}};
         bus.tuser    <= pack_user(1'b0, EOP_ONE, 2'h0, second_off, 4'h0);
      end
      else if (accepted)
      begin
         state      <= ST_IDLE;
         bus.tvalid <= 1'b0;
         bus.tlast  <= 1'b0;
         bus.tuser  <= '0;
      end
   end

endmodule

`default_nettype wire

// [bench/rq_stream_chk.sv]
`default_nettype none
module rq_stream_chk
   import rq_stream_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic              i_reset_n,
   input  wire logic              tvalid,
   input  wire logic              tready,
   input  wire logic              tlast,
   input  wire logic [DATA_W-1:0] tdata,
   input  wire logic [USER_W-1:0] tuser
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       in_pkt;
   logic [7:0] last_idx;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_reset_n);
   //////////////////////////////////////////////////////////////
   // tracks packet position, first beat has no open packet
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         in_pkt   <= 1'b0;
         last_idx <= 8'h00;
      end
      else if (tvalid && tready)
      begin
         in_pkt   <= !tlast;
         last_idx <= tdata[7:0];
      end
   end
   //////////////////////////////////////////////////////////////
   sequence s_acc;
      tvalid && tready;
   endsequence
   sequence s_stall;
      tvalid && !tready;
   endsequence
   sequence s_abort_end;
      s_acc ##0 (tuser[ABORT_BIT] && tuser[EOP_LSB]);
   endsequence
   sequence s_mid_beat;
      s_acc ##0 (in_pkt && tdata[31:0] != 32'hffffffff);
   endsequence
   AST_SOP1_LEGAL: assert property (s_acc ##0 (tuser[25:24] != 2'h0) |-> tuser[25:24] == SOP1_LANE32)
      else $error("second start lane code reserved");
   AST_EOP_LEGAL: assert property (s_acc |-> tuser[27:26] != 2'h2)
      else $error("end flags reserved code");
   AST_LAST_FLAG: assert property (s_acc ##0 tlast |-> tuser[EOP_LSB])
      else $error("tlast beat without low end flag");
   AST_HOLD: assert property (s_stall |=> tvalid && $stable(tuser) && $stable(tlast) && $stable(tdata))
      else $error("beat changed before ready");
   AST_ABORT_FIRST: assert property (s_acc ##0 !in_pkt |-> !tuser[ABORT_BIT])
      else $error("abort in first beat");
   AST_NO_START_ON_ABORT: assert property (s_abort_end |-> tuser[25:24] != SOP1_LANE32)
      else $error("new packet beside aborted end");
   AST_CONTINUE: assert property (s_acc ##0 !tlast |=> tvalid)
      else $error("packet dropped before end");
   AST_BEAT_ORDER: assert property (s_mid_beat |-> tdata[7:0] == last_idx + 8'h01)
      else $error("beat index out of order");
endmodule
`default_nettype wire

// [bench/request_stream_eop_discontinue_tb_top.sv]
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module request_stream_eop_discontinue_tb_top;
   import rq_stream_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, reset_n, link_rdy, str_en, ep_mode, wr_s, rd_s;
   logic        sent, nul, aer, irq;
   logic [3:0]  addr, last_off;
   logic [31:0] wdata, rdata, lfsr, stall_r;
   logic [15:0] cnt, exp_cnt, exp_bts;
   int          err_count, n_checks, sent_n, nul_n, aer_n;
   rq_stream_if bus_if();
   rq_stream_core u_rq_stream_core (.i_ref_clk(ref_clk), .i_reset_n(reset_n), .bus(bus_if),
      .i_link_ready(link_rdy), .i_straddle_en(str_en), .i_endpoint_mode(ep_mode), .o_tlp_sent(sent),
      .o_tlp_nullified(nul), .o_aer_report(aer), .o_last_offset(last_off), .o_tlp_count(cnt));
   rq_stream_user u_rq_stream_user (.i_ref_clk(ref_clk), .i_reset_n(reset_n), .bus(bus_if), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_irq(irq));
   rq_stream_chk u_chk (.i_ref_clk(ref_clk), .i_reset_n(reset_n), .tvalid(bus_if.tvalid),
      .tready(bus_if.tready), .tlast(bus_if.tlast), .tdata(bus_if.tdata), .tuser(bus_if.tuser));
   //////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // random stalls, ready high three beats in four
   always @(posedge ref_clk)
   begin
      if (!reset_n)
         stall_r <= 32'h1d9b2186;
      else
         stall_r <= lfsr_next(stall_r);
      link_rdy <= stall_r[1:0] != 2'h0;
   end
   always @(posedge ref_clk)
   begin
      if (!reset_n)
         {sent_n, nul_n, aer_n} <= '0;
      else
      begin
         sent_n <= sent_n + int'(sent === 1'b1);
         nul_n  <= nul_n + int'(nul === 1'b1);
         aer_n  <= aer_n + int'(aer === 1'b1);
      end
   end
   //////////////////////////////////////////////////////////////
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge ref_clk);
      wr_s  <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge ref_clk);
      rd_s <= 1'b0;
      @(posedge ref_clk);
      d = rdata;
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // an aborted pair still leaves one clean TLP behind it
   function automatic int exp_good(input logic abrt, input logic two);
      return abrt ? int'(two) : 1 + int'(two);
   endfunction
   // aborted pair ending adds one tail beat
   function automatic int exp_beats(input logic [7:0] len, input logic [7:0] ab, input logic cut, input logic two);
      logic hit;
      hit = ab != 8'h0 && ab < len;
      return (hit && cut) ? ab + 1 + int'(two) : len + int'(hit && two && ab == len - 8'h1);
   endfunction
   task automatic run_pkt(input logic [7:0] len, input logic [7:0] ab, input logic cut, input logic str,
      input logic pair, input logic ep, input logic [3:0] o0, input logic [3:0] o1);
      logic [31:0] v;
      logic        abrt;
      logic        two;
      int          k, s0, n0, a0;
      abrt = ab != 8'h0 && ab < len;
      two  = str && pair;
      str_en  <= str;
      ep_mode <= ep;
      wr(REG_LENGTH, {24'h0, len});
      wr(REG_ABORT_BEAT, {24'h0, ab});
      wr(REG_OFFSETS, {24'h0, o1, o0});
      wr(REG_IRQ_ENABLE, 32'h3);
      s0 = sent_n;
      n0 = nul_n;
      a0 = aer_n;
      wr(REG_CTRL, {28'h0, pair, cut, str, 1'b1});
      k = 0;
      v = 32'h10;
      while (v[CTRL_BUSY] !== 1'b0 && k < 300)
      begin
         rd(REG_CTRL, v);
         k++;
      end
      `CHK("busy", 1'b0, v[CTRL_BUSY])
      repeat (2) @(posedge ref_clk);
      #1;
      exp_cnt = exp_cnt + 16'(exp_good(abrt, two));
      exp_bts = exp_bts + 16'(exp_beats(len, ab, cut, two));
      `CHK("tlp count", exp_cnt, cnt)
      `CHK("sent pulses", int'(exp_good(abrt, two) != 0), sent_n - s0)
      `CHK("nullified pulses", int'(abrt), nul_n - n0)
      `CHK("error reports", int'(abrt && ep), aer_n - a0)
      if (two)
         `CHK("last offset", o1, last_off)
      else
         `CHK("last offset", o0, last_off)
      `CHK("irq", 1'b1, irq)
      rd(REG_IRQ_STATUS, v);
      `CHK("aborted status", abrt, v[IRQ_ABORTED])
      rd(REG_BEATS_SENT, v);
      `CHK("beats sent", {16'h0, exp_bts}, v)
      wr(REG_IRQ_ENABLE, 32'h0);
      repeat (2) @(posedge ref_clk);
      `CHK("masked irq", 1'b0, irq)
      wr(REG_IRQ_CLEAR, 32'h3);
      rd(REG_IRQ_STATUS, v);
      `CHK("cleared status", 2'h0, v[1:0])
   endtask
   //////////////////////////////////////////////////////////////
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      err_count++;
      final_report();
   end
   initial
   begin
      logic [31:0] v;
      logic [7:0]  ab;
      {reset_n, str_en, ep_mode, wr_s, rd_s, addr, wdata} = '0;
      {err_count, n_checks} = '0;
      lfsr    = 32'h1d9b2186;
      exp_cnt = 16'h0;
      exp_bts = 16'h0;
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(REG_LENGTH, v);
      `CHK("length reset", {24'h0, LENGTH_RESET}, v)
      rd(4'h9, v);
      `CHK("unmapped read", 32'h0, v)
      wr(REG_LENGTH, 32'h0);
      rd(REG_LENGTH, v);
      `CHK("length zero", 32'h1, v)
      run_pkt(8'h1, 8'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3, 4'h0);
      run_pkt(8'h4, 8'h3, 1'b0, 1'b0, 1'b0, 1'b1, 4'h1, 4'h0);
      run_pkt(8'h5, 8'h2, 1'b0, 1'b1, 1'b0, 1'b1, 4'h2, 4'h0);
      run_pkt(8'h5, 8'h2, 1'b1, 1'b1, 1'b0, 1'b0, 4'h4, 4'h0);
      run_pkt(8'h3, 8'h0, 1'b0, 1'b1, 1'b1, 1'b0, 4'h5, 4'ha);
      run_pkt(8'h2, 8'h0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h6, 4'hb);
      run_pkt(8'h3, 8'h7, 1'b0, 1'b0, 1'b0, 1'b1, 4'hf, 4'h0);
      run_pkt(8'h4, 8'h3, 1'b0, 1'b1, 1'b1, 1'b1, 4'h7, 4'h9);
      run_pkt(8'h6, 8'h2, 1'b1, 1'b1, 1'b1, 1'b0, 4'h8, 4'hc);
      run_pkt(8'h5, 8'h1, 1'b0, 1'b1, 1'b1, 1'b1, 4'h1, 4'h2);
      run_pkt(8'h1, 8'h0, 1'b0, 1'b1, 1'b1, 1'b0, 4'h3, 4'hd);
      repeat (24)
      begin
         lfsr = lfsr_next(lfsr);
         v    = lfsr;
         ab   = v[4] ? {5'h0, v[7:5]} : 8'h0;
         run_pkt({5'h0, v[2:0]} + 8'h1, ab, v[9], v[10], v[8], v[11], v[15:12], v[19:16]);
      end
      final_report();
   end
endmodule
`default_nettype wire
